/* File: dewc_pkg.sv */
// dewc_pkg: constants and types for the data nonvolatile write controller
// assumes: 50 MHz system clock, 32-bit axi4-lite register access
package dewc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned WRITE_TIME_US = 4000; // nominal write cycle time
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned OFS_W = 4;
  // register byte addresses
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ADDRESS = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_POINTER = 8'h0C;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  // control register fields
  localparam int unsigned BIT_PAGE_MODE = 4;
  localparam int unsigned BIT_PROG_EN = 3;
  localparam int unsigned BIT_PROG_START = 2;
  localparam int unsigned BIT_FETCH_EN = 1;
  localparam int unsigned BIT_FETCH_START = 0;
  // indirect window holding the control register
  localparam logic [7:0] CTRL_PTR_LOW = 8'h40;
  localparam logic [7:0] CTRL_PTR_HIGH = 8'h01;
  // irq register fields
  localparam int unsigned BIT_IRQ_FLAG = 0;
  localparam int unsigned BIT_IRQ_EN = 1;
  localparam int unsigned BIT_MF_FLAG = 2;
  localparam int unsigned BIT_MF_EN = 3;
  localparam int unsigned BIT_GIE = 4;
  localparam int unsigned BIT_STACK_FULL = 5;
  localparam logic [OFS_W-1:0] OFS_LAST = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM} dewc_state_type;
  typedef struct packed {
    logic write_en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } dewc_array_req_type;
endpackage

/* File: dewc_page_buffer.sv */
// dewc_page_buffer: 16-byte page buffer with synchronous clear
// assumes: single clock, clear has priority over write
`timescale 1ns/100ps
`default_nettype none
module dewc_page_buffer (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clear, // wipe all bytes
  input wire logic wr, // store one byte
  input wire logic [dewc_pkg::OFS_W-1:0] wr_ofs, // byte slot to store
  input wire logic [7:0] wr_data, // byte to store
  input wire logic [dewc_pkg::OFS_W-1:0] rd_ofs, // byte slot to read
  output logic [7:0] rd_data // registered read byte
);
  logic [7:0] mem [dewc_pkg::PAGE_BYTES];

  // storage; clear wins so a dropped enable never leaves stale data
  always_ff @(posedge clk) begin
    for (int i = 0; i < dewc_pkg::PAGE_BYTES; i++) begin
      if (sys_rst || clear) begin
        mem[i] <= 8'h00;
      end else if (wr && wr_ofs == dewc_pkg::OFS_W'(i)) begin
        mem[i] <= wr_data;
      end
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_ofs];
    end
  end
endmodule
`default_nettype wire

/* File: dewc_write_ctrl.sv */
// dewc_write_ctrl: write side of the data nonvolatile memory controller
// assumes: axi4-lite master, array accepts a request per cycle, timer tick from async timer
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dewc_write_ctrl #(
  parameter int unsigned WRITE_CYCLES = dewc_pkg::WRITE_CYCLES // write time in timer ticks
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic timer_tick, // asynchronous write timer clock as a level
  input wire logic irq_serviced, // cpu entered the shared vector
  input wire logic stack_full, // call stack has no room
  output logic irq_vector_req, // shared vector jump request
  output dewc_pkg::dewc_array_req_type array_req, // request to the storage array
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  logic page_mode, program_enable, program_start, fetch_enable, fetch_start;
  logic [dewc_pkg::ADDR_W-1:0] nvm_address_reg;
  logic [7:0] nvm_data_reg;
  logic [7:0] pointer_high_byte_one, pointer_low_byte_one;
  logic nvm_irq_flag, nvm_irq_enable, mf_flag, mf_enable, global_irq_enable;
  logic [7:0] aw_addr, ar_addr;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, ctrl_sel, ctrl_wr, data_wr, prev_enable, page_full;
  logic [7:0] ctrl_byte, next_ctrl;
  logic [2:0] tick_sync;
  logic tick_edge, tick_level, cycle_done, buf_clear;
  logic [31:0] tick_count;
  logic [dewc_pkg::OFS_W-1:0] prog_ofs;
  logic [7:0] buf_rd;
  logic [1:0] buf_wait;
  dewc_pkg::dewc_state_type state;

  // a plain byte write from the bus, lane 0 steered by strobe 0
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction

  // write channel capture; address and data may arrive in any order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dewc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        dewc_pkg::OFF_CONTROL, dewc_pkg::OFF_ADDRESS, dewc_pkg::OFF_DATA, dewc_pkg::OFF_POINTER,
        dewc_pkg::OFF_IRQ: s_axi_bresp <= dewc_pkg::RESP_OKAY;
        default: s_axi_bresp <= dewc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register only answers when the pointer selects its window
  assign ctrl_sel = pointer_high_byte_one == dewc_pkg::CTRL_PTR_HIGH
                    && pointer_low_byte_one == dewc_pkg::CTRL_PTR_LOW;
  assign ctrl_wr = wr_fire && aw_addr == dewc_pkg::OFF_CONTROL && ctrl_sel && w_strb[0];
  assign data_wr = wr_fire && aw_addr == dewc_pkg::OFF_DATA && w_strb[0];
  assign ctrl_byte = {3'h0, page_mode, program_enable, program_start, fetch_enable, fetch_start};
  assign next_ctrl = merge_byte(ctrl_byte, w_data, w_strb);

  // control bits; start only takes while enable already stands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_mode <= 1'b0;
      program_enable <= 1'b0;
      program_start <= 1'b0;
      fetch_enable <= 1'b0;
      fetch_start <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        page_mode <= next_ctrl[dewc_pkg::BIT_PAGE_MODE];
        fetch_enable <= next_ctrl[dewc_pkg::BIT_FETCH_EN];
        // fetch side lives elsewhere; accepted only without a write start
        fetch_start <= next_ctrl[dewc_pkg::BIT_FETCH_START] && fetch_enable
                       && !next_ctrl[dewc_pkg::BIT_PROG_START];
      end
      if (cycle_done) begin
        program_start <= 1'b0;
        if (page_mode) begin
          program_enable <= 1'b0;
        end else if (ctrl_wr) begin
          program_enable <= next_ctrl[dewc_pkg::BIT_PROG_EN];
        end
      end else if (ctrl_wr) begin
        program_enable <= next_ctrl[dewc_pkg::BIT_PROG_EN];
        // software cannot cancel a running cycle by writing zero
        if (!program_start) begin
          program_start <= next_ctrl[dewc_pkg::BIT_PROG_START] && program_enable;
        end
      end
    end
  end

  // address, data and pointer registers; page mode advances the low nibble
  assign page_full = nvm_address_reg[dewc_pkg::OFS_W-1:0] == dewc_pkg::OFS_LAST;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nvm_address_reg <= '0;
      nvm_data_reg <= 8'h00;
      pointer_high_byte_one <= 8'h00;
      pointer_low_byte_one <= 8'h00;
    end else begin
      if (wr_fire && aw_addr == dewc_pkg::OFF_ADDRESS && w_strb[0] && !program_start) begin
        nvm_address_reg <= w_data[dewc_pkg::ADDR_W-1:0];
      end else if (data_wr && page_mode && !program_start) begin
        if (!page_full) begin
          nvm_address_reg[dewc_pkg::OFS_W-1:0] <= nvm_address_reg[dewc_pkg::OFS_W-1:0] + 4'h1;
        end
      end
      if (data_wr && !program_start) begin
        nvm_data_reg <= w_data[7:0];
      end
      if (wr_fire && aw_addr == dewc_pkg::OFF_POINTER) begin
        if (w_strb[0]) pointer_low_byte_one <= w_data[7:0];
        if (w_strb[1]) pointer_high_byte_one <= w_data[15:8];
      end
    end
  end

  // the slot at the page end takes one byte; saturation follows the address, not a count
  logic last_taken;
  always_ff @(posedge clk) begin
    if (sys_rst || buf_clear) begin
      last_taken <= 1'b0;
    end else if (wr_fire && aw_addr == dewc_pkg::OFF_ADDRESS && w_strb[0] && !program_start) begin
      last_taken <= 1'b0; // a new start address reopens the page
    end else if (data_wr && page_mode && !program_start && page_full) begin
      last_taken <= 1'b1;
    end
  end

  // buffer clears on reset or a falling program_enable, never on a rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_enable <= 1'b0;
    end else begin
      prev_enable <= program_enable;
    end
  end
  assign buf_clear = prev_enable && !program_enable;

  dewc_page_buffer u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(buf_clear),
    .wr(data_wr && page_mode && !program_start && !last_taken),
    .wr_ofs(nvm_address_reg[dewc_pkg::OFS_W-1:0]),
    .wr_data(w_data[7:0]),
    .rd_ofs(prog_ofs),
    .rd_data(buf_rd)
  );

  // timer tick from a foreign clock: three flops, a rise counts once the last two agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_sync <= 3'h0;
      tick_level <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[1:0], timer_tick};
      if (tick_sync[1] == tick_sync[2]) tick_level <= tick_sync[2];
    end
  end
  assign tick_edge = tick_sync[1] && tick_sync[2] && !tick_level;

  // cycle sequencer; the end also waits for the array walk, so a short timer cannot cut a page
  assign cycle_done = state == dewc_pkg::ST_PROGRAM && buf_wait == 2'h3
                      && tick_count >= WRITE_CYCLES - 1 && tick_edge;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= dewc_pkg::ST_IDLE;
      tick_count <= 32'h0000_0000;
    end else begin
      case (state)
        dewc_pkg::ST_IDLE: begin
          tick_count <= 32'h0000_0000;
          if (program_start) begin
            state <= page_mode ? dewc_pkg::ST_PROGRAM : dewc_pkg::ST_ERASE;
          end
        end
        dewc_pkg::ST_ERASE: begin
          // the first WRITE_CYCLES/2 + 1 ticks of the timed cycle are the automatic byte erase
          if (tick_edge) tick_count <= tick_count + 32'h1;
          if (tick_edge && tick_count >= (WRITE_CYCLES / 2)) state <= dewc_pkg::ST_PROGRAM;
        end
        dewc_pkg::ST_PROGRAM: begin
          if (tick_edge) tick_count <= tick_count + 32'h1;
          if (cycle_done) state <= dewc_pkg::ST_IDLE;
        end
        default: state <= dewc_pkg::ST_IDLE;
      endcase
    end
  end

  // array requests: byte mode erase writes zero, then program byte; page mode walks the buffer with no erase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      array_req <= '0;
      prog_ofs <= '0;
      buf_wait <= 2'h0;
    end else begin
      array_req.write_en <= 1'b0;
      if (state == dewc_pkg::ST_IDLE) begin
        prog_ofs <= '0;
        buf_wait <= 2'h0;
        if (program_start && !page_mode) begin
          array_req <= '{write_en: 1'b1, addr: nvm_address_reg, data: 8'h00};
        end
      end else if (state == dewc_pkg::ST_PROGRAM && buf_wait != 2'h3) begin
        if (!page_mode) begin
          array_req <= '{write_en: 1'b1, addr: nvm_address_reg, data: nvm_data_reg};
          buf_wait <= 2'h3;
        end else if (buf_wait == 2'h0) begin
          buf_wait <= 2'h1; // wait out registered buffer read
        end else begin
          array_req <= '{write_en: 1'b1, addr: {nvm_address_reg[dewc_pkg::ADDR_W-1:dewc_pkg::OFS_W], prog_ofs},
                         data: buf_rd};
          prog_ofs <= prog_ofs + 4'h1;
          buf_wait <= (prog_ofs == dewc_pkg::OFS_LAST) ? 2'h3 : 2'h0;
        end
      end
    end
  end

  // interrupt flags; set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nvm_irq_flag <= 1'b0;
      nvm_irq_enable <= 1'b0;
      mf_flag <= 1'b0;
      mf_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == dewc_pkg::OFF_IRQ && w_strb[0]) begin
        nvm_irq_flag <= w_data[dewc_pkg::BIT_IRQ_FLAG];
        nvm_irq_enable <= w_data[dewc_pkg::BIT_IRQ_EN];
        mf_flag <= w_data[dewc_pkg::BIT_MF_FLAG];
        mf_enable <= w_data[dewc_pkg::BIT_MF_EN];
        global_irq_enable <= w_data[dewc_pkg::BIT_GIE];
      end
      if (irq_serviced) begin
        mf_flag <= 1'b0;
        global_irq_enable <= 1'b0;
      end
      if (cycle_done) begin
        nvm_irq_flag <= 1'b1;
        mf_flag <= 1'b1;
      end
    end
  end
  assign irq_vector_req = global_irq_enable && nvm_irq_enable && mf_enable && mf_flag && nvm_irq_flag
                          && !stack_full;

  // read channel: one answer per address, data registered
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dewc_pkg::RESP_OKAY;
      ar_addr <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      ar_addr <= s_axi_araddr[7:0];
      s_axi_rresp <= dewc_pkg::RESP_OKAY;
      case (s_axi_araddr[7:0])
        dewc_pkg::OFF_CONTROL: s_axi_rdata <= ctrl_sel ? {24'h0, ctrl_byte} : 32'h0000_0000;
        dewc_pkg::OFF_ADDRESS: s_axi_rdata <= {25'h0, nvm_address_reg};
        dewc_pkg::OFF_DATA: s_axi_rdata <= {24'h0, nvm_data_reg};
        dewc_pkg::OFF_POINTER: s_axi_rdata <= {16'h0, pointer_high_byte_one, pointer_low_byte_one};
        dewc_pkg::OFF_IRQ: s_axi_rdata <= {26'h0, stack_full, global_irq_enable, mf_enable, mf_flag,
                                           nvm_irq_enable, nvm_irq_flag};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= dewc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: dewc_array_model.sv */
// dewc_array_model: storage array beside the write controller, with its own write timer
// assumes: at most one array request per clock, timer unrelated in phase to clk
`timescale 1ns/100ps
`default_nettype none
module dewc_array_model (
  input wire logic clk, // system clock
  input wire dewc_pkg::dewc_array_req_type req, // request from the controller
  output logic timer_tick // write timer clock
);
  logic [7:0] mem [0:127];
  dewc_pkg::dewc_array_req_type log_q[$];
  // the timer has its own oscillator, so its edges drift against clk
  initial begin
    timer_tick = 1'b0;
    forever #53 timer_tick = ~timer_tick;
  end
  // the array starts erased, as a prior page erase leaves it
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
  end
  // keep every pulsed byte and the order it came in, erase pulses too
  always @(posedge clk) begin
    if (req.write_en === 1'b1) begin
      mem[req.addr] <= req.data;
      log_q.push_back(req);
    end
  end
endmodule
`default_nettype wire

/* File: dewc_write_ctrl_properties.sv */
// dewc_write_ctrl_properties: port-level checks of the write controller
// assumes: bound to dewc_write_ctrl, one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module dewc_write_ctrl_properties (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic irq_serviced, // vector entered
  input wire logic stack_full, // no stack room
  input wire logic irq_vector_req, // vector request
  input wire dewc_pkg::dewc_array_req_type array_req, // array request
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // r response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  // reset has no disable here: the check is about what reset leaves behind
  a_reset_idle: assert property (@(posedge clk) sys_rst |=> !s_axi_bvalid && !s_axi_rvalid
    && !irq_vector_req && !array_req.write_en) else $error("outputs not idle after reset");
  a_vec_gate: assert property (@(posedge clk) disable iff (sys_rst) stack_full |-> !irq_vector_req)
    else $error("vector request with full stack");
  a_service_clear: assert property (@(posedge clk) disable iff (sys_rst) irq_serviced |=> !irq_vector_req)
    else $error("vector request survives service");
  a_bvalid_hold: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rvalid_hold: assert property (@(posedge clk) disable iff (sys_rst) s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read response dropped");
  // both halves are held one edge, the write acts the next, the response stands after that
  a_b_answer: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response");
  a_r_answer: assert property (@(posedge clk) disable iff (sys_rst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst) s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 32'h00000020 |=> s_axi_rresp == dewc_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
endmodule
bind dewc_write_ctrl dewc_write_ctrl_properties u_chk (.clk, .sys_rst, .irq_serviced, .stack_full,
  .irq_vector_req, .array_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* File: tb_top.sv */
// tb_top: self-checking bench for the write controller over axi4-lite
// assumes: array model supplies the write timer, write time shortened to 4 ticks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, sys_rst, irq_serviced, stack_full, irq_vector_req;
  wire logic timer_tick;
  dewc_pkg::dewc_array_req_type array_req;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] pd [0:5];
  logic [6:0] a, pg;
  logic [7:0] d;
  int err_total, checks_done, n0;
  integer seed;
  dewc_write_ctrl #(.WRITE_CYCLES(4)) uut (.clk, .sys_rst, .timer_tick, .irq_serviced, .stack_full,
    .irq_vector_req, .array_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dewc_array_model u_arr (.clk, .req(array_req), .timer_tick);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a wait that runs dry counts as a mismatch and ends the run
  task automatic hung();
    err_total++;
    tally_and_finish();
  endtask
  // address and data offered together, each dropped once taken; bready waits for bvalid
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    int k;
    @(posedge clk);
    s_axi_awaddr <= {24'h000000, ad};
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (k == 40) hung();
  endtask
  // rready comes a cycle late so the slave must hold its answer
  task automatic rd(input logic [7:0] ad);
    int k;
    @(posedge clk);
    s_axi_araddr <= {24'h000000, ad};
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 40) hung();
  endtask
  // poll the start bit without idling, then check the whole control word left behind
  task automatic wait_done(input logic [31:0] exp);
    int k;
    for (k = 0; k < 300; k++) begin
      rd(8'h00);
      if (rd_d[2] === 1'b0) break;
    end
    if (k == 300) hung();
    cmp(rd_d, exp);
  endtask
  // enable stays clear while the buffer fills, raised only for the start
  task automatic page(input logic [6:0] ad, input int n);
    wr(8'h00, 32'h00000010);
    wr(8'h04, {25'h0, ad});
    for (int i = 0; i < n; i++) begin
      pd[i] = 8'($random(seed));
      wr(8'h08, {24'h0, pd[i]});
    end
    n0 = u_arr.log_q.size();
    wr(8'h00, 32'h00000018);
    wr(8'h00, 32'h0000001C);
    wait_done(32'h00000010);
    cmp(32'(u_arr.log_q.size() - n0), 32'h00000010);
  endtask
  initial begin
    seed = 59;
    {sys_rst, irq_serviced, stack_full} = 3'b100;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h00000000;
    s_axi_wdata = 32'h00000000;
    s_axi_araddr = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // hidden control: pointer starts at zero, so control writes vanish
    rd(8'h0C);
    cmp(rd_d, 32'h00000000);
    wr(8'h00, 32'h00000008);
    wr(8'h0C, 32'h00000140);
    rd(8'h00);
    cmp(rd_d, 32'h00000000);
    wr(8'h00, 32'h00000004);
    rd(8'h00);
    cmp(rd_d, 32'h00000000);
    cmp(32'(u_arr.log_q.size()), 32'h00000000);
    // fetch bits sit in their own lanes and start no write
    wr(8'h00, 32'h00000002);
    wr(8'h00, 32'h00000003);
    rd(8'h00);
    cmp(rd_d, 32'h00000003);
    rd(8'h20);
    cmp({30'h0, rd_r}, {30'h0, dewc_pkg::RESP_SLVERR});
    // byte write at a random place: erase pulse, then program pulse
    a = 7'($random(seed));
    d = 8'($random(seed)) | 8'h01;
    wr(8'h04, {25'h0, a});
    wr(8'h08, {24'h0, d});
    wr(8'h00, 32'h00000008);
    wr(8'h00, 32'h0000000C);
    rd(8'h00);
    cmp({31'h0, rd_d[2]}, 32'h00000001);
    wait_done(32'h00000008);
    cmp(32'(u_arr.log_q.size()), 32'h00000002);
    cmp({16'h0, u_arr.log_q[0]}, {16'h0, 1'b1, a, 8'h00});
    cmp({16'h0, u_arr.log_q[1]}, {16'h0, 1'b1, a, d});
    rd(8'h10);
    cmp({26'h0, rd_d[5:0]}, 32'h00000005);
    // enable everything, then block by stack, then service
    wr(8'h10, 32'h0000001F);
    cmp({31'h0, irq_vector_req}, 32'h00000001);
    stack_full <= 1'b1;
    @(posedge clk);
    cmp({31'h0, irq_vector_req}, 32'h00000000);
    stack_full <= 1'b0;
    irq_serviced <= 1'b1;
    @(posedge clk);
    irq_serviced <= 1'b0;
    @(posedge clk);
    cmp({31'h0, irq_vector_req}, 32'h00000000);
    rd(8'h10);
    cmp({26'h0, rd_d[5:0]}, 32'h0000000B);
    wr(8'h10, 32'h00000000);
    // page from offset C with six bytes: the last two fall past the end
    pg = {a[6:4], 4'hC};
    page(pg, 6);
    for (int i = 0; i < 4; i++) cmp({24'h0, u_arr.mem[pg + i]}, {24'h0, pd[i]});
    cmp({24'h0, u_arr.mem[{pg[6:4], 4'hF}]}, {24'h0, pd[3]});
    cmp({24'h0, u_arr.mem[{pg[6:4], 4'h0}]}, 32'h00000000);
    rd(8'h04);
    cmp(rd_d, {25'h0, pg[6:4], 4'hF});
    // second page writes only F: a stale buffer would reprogram E
    page({pg[6:4], 4'hF}, 1);
    cmp({24'h0, u_arr.mem[{pg[6:4], 4'hF}]}, {24'h0, pd[0]});
    cmp({24'h0, u_arr.mem[{pg[6:4], 4'hE}]}, 32'h00000000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
